// File: sfcd_hold_cnt.sv
// counts enable ticks after reset and flags when a target is reached
`timescale 1ns/1ps
module sfcd_hold_cnt #(
  parameter int unsigned W = 10
) (
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  input  wire logic         tick,
  input  wire logic [W-1:0] target,
  output logic              done
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // ==========================================================================
  // count, saturating at the target
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (tick && (cnt_r < target))
      cnt_nxt = cnt_r + 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cnt_r <= '0;
      done  <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      done  <= (cnt_r >= target);
    end
  end
endmodule

// File: sfcd_pkg.sv
// constants for the system fuse configuration decoder
package sfcd_pkg;

  // ==========================================================================
  // clock and timing
  localparam int unsigned CLK_HZ          = 250_000_000;
  localparam int unsigned SLOW_OSC_HZ     = 32_768;
  localparam int unsigned MS_PER_S        = 1_000;
  // one low-power oscillator period, rounded up so the hold is never short
  localparam int unsigned SLOW_OSC_DIV    = (CLK_HZ + SLOW_OSC_HZ - 1) / SLOW_OSC_HZ;
  localparam int unsigned MS_DIV          = CLK_HZ / MS_PER_S;
  localparam int unsigned GPIO_HOLD_TICKS = 768;
  localparam int unsigned FLASH_BLOCKS    = 16;

  // ==========================================================================
  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_CFG0     = 8'h05;
  localparam logic [7:0] IDX_CFG1     = 8'h06;
  localparam logic [7:0] IDX_APP_END  = 8'h07;
  localparam logic [7:0] IDX_BOOT_END = 8'h08;
  localparam logic [7:0] IDX_LOCK     = 8'h0A;
  localparam logic [7:0] IDX_STATUS   = 8'h0B;
  localparam logic [7:0] IDX_ERASE    = 8'h0C;

  // ==========================================================================
  // factory values of the stored bytes
  localparam logic [7:0] RST_CFG0     = 8'hF6;
  localparam logic [7:0] RST_CFG1     = 8'h07;
  localparam logic [7:0] RST_APP_END  = 8'h00;
  localparam logic [7:0] RST_BOOT_END = 8'h00;
  localparam logic [7:0] RST_LOCK     = 8'hC5;

  // ==========================================================================
  // field positions and codes
  localparam int unsigned SCAN_LSB  = 6;
  localparam int unsigned PIN_LSB   = 2;
  localparam int unsigned KEEP_BIT  = 0;
  localparam int unsigned START_LSB = 0;
  localparam int unsigned STAT_GPIO = 0;
  localparam int unsigned STAT_RUN  = 1;
  localparam int unsigned STAT_LOCK = 2;
  localparam int unsigned ERASE_BIT = 0;

  localparam logic [1:0] SCAN_FULL         = 2'h0;
  localparam logic [1:0] SCAN_BOOT         = 2'h1;
  localparam logic [1:0] SCAN_BOOT_AND_APP = 2'h2;
  localparam logic [1:0] SCAN_DISABLED     = 2'h3;
  localparam logic [1:0] PIN_GPIO          = 2'h0;
  localparam logic [1:0] PIN_PROG          = 2'h1;
  localparam logic [1:0] PIN_RESET         = 2'h2;
  localparam logic [7:0] UNLOCK_KEY        = 8'hC5;

endpackage

// File: sfcd_tb_top.sv
// self-checking testbench for the fuse configuration decoder
`timescale 1ns/1ps
module sfcd_tb_top;
  import sfcd_pkg::*;

  // ==========================================================================
  // shortened dividers keep the 64 ms and 768-tick waits short
  localparam int unsigned OD  = 4;
  localparam int unsigned MD  = 10;
  localparam int          CAP = 30000;

  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire logic   hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [7:0]  nv_cfg0 = 8'hF6;
  logic [7:0]  nv_cfg1 = 8'h07;
  logic [7:0]  nv_app_end = 8'h00;
  logic [7:0]  nv_boot_end = 8'h00;
  logic [7:0]  nv_lock_key = 8'hC5;
  logic        prog_bus_req = 1'b0;
  logic        prog_info_req = 1'b0;
  logic        prog_bus_grant, prog_info_grant, scan_enable, pin_func_gpio, pin_func_prog;
  logic        pin_func_reset, gpio_drive_allow, startup_done, chip_erase_stb, eeprom_erase;
  logic        lock_wr_stb;
  logic [1:0]  scan_region_select;
  logic [8:0]  scan_limit_blk, boot_limit_blk, app_limit_blk;
  logic [7:0]  lock_wr_data;
  int          err_total = 0;
  int          n_compared = 0;
  int          cyc = 0;

  // single slave: its ready is the bus ready
  assign hready = hreadyout;

  always #2 ref_clk = ~ref_clk;

  sfcd_top #(.OSC_DIV(OD), .MSEC_DIV(MD), .HOLD_TICKS(768), .FLASH_BLK(16)) i_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .nv_cfg0(nv_cfg0), .nv_cfg1(nv_cfg1), .nv_app_end(nv_app_end),
    .nv_boot_end(nv_boot_end), .nv_lock_key(nv_lock_key), .prog_bus_req(prog_bus_req),
    .prog_info_req(prog_info_req), .prog_bus_grant(prog_bus_grant), .prog_info_grant(prog_info_grant),
    .scan_enable(scan_enable), .scan_region_select(scan_region_select),
    .scan_limit_blk(scan_limit_blk), .boot_limit_blk(boot_limit_blk), .app_limit_blk(app_limit_blk),
    .pin_func_gpio(pin_func_gpio), .pin_func_prog(pin_func_prog), .pin_func_reset(pin_func_reset),
    .gpio_drive_allow(gpio_drive_allow), .startup_done(startup_done),
    .chip_erase_stb(chip_erase_stb), .eeprom_erase(eeprom_erase), .lock_wr_stb(lock_wr_stb),
    .lock_wr_data(lock_wr_data)
  );

  // ==========================================================================
  // helpers
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, m, g, e);
    end
  endtask

  // hang guard; the longest test needs about 13k cycles
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == CAP)
    begin
      err_total++;
      $display("unexpected at %0t: timeout", $time);
      conclude();
    end
  end

  task automatic rst_with(input logic [7:0] c0, c1, ap, bt, lk);
    @(posedge ref_clk);
    nv_cfg0 <= c0;
    nv_cfg1 <= c1;
    nv_app_end <= ap;
    nv_boot_end <= bt;
    nv_lock_key <= lk;
    sys_rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
  endtask

  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  // address phase held until ready, data phase until ready again
  task automatic ahb_rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= 1'b0;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    do @(posedge ref_clk); while (hready !== 1'b1);
    d = hrdata;
    chk(hresp, 1'b0, "okay response");
  endtask

  task automatic ahb_wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= v;
    do @(posedge ref_clk); while (hready !== 1'b1);
    #1;
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_regs();
    logic [31:0] d;
    logic [31:0] ad [5] = '{32'h14, 32'h18, 32'h1C, 32'h20, 32'h28};
    logic [31:0] ex [5] = '{32'hF6, 32'h07, 32'h00, 32'h00, 32'hC5};
    rst_with(RST_CFG0, RST_CFG1, RST_APP_END, RST_BOOT_END, RST_LOCK);
    settle();
    for (int i = 0; i < 5; i++)
    begin
      ahb_rd(ad[i], d);
      chk(d, ex[i], "reg read");
    end
    ahb_rd(32'h24, d);
    chk(d, 32'h0, "unmapped read");
    ahb_wr(32'h14, 32'h0);
    ahb_rd(32'h14, d);
    chk(d, 32'hF6, "read-only write");
    ahb_wr(32'h28, 32'h3A);
    chk(lock_wr_stb, 1'b1, "lock strobe");
    chk(lock_wr_data, 8'h3A, "lock data");
    nv_cfg0 <= 8'h01;
    ahb_rd(32'h28, d);
    chk(d, 32'hC5, "lock held");
    ahb_rd(32'h14, d);
    chk(d, 32'hF6, "capture held");
    chk(scan_region_select, 2'h3, "scan held");
  endtask

  task automatic t_scan();
    logic [8:0] lim [4] = '{9'd16, 9'd4, 9'd10, 9'd0};
    for (int k = 0; k < 4; k++)
    begin
      rst_with({k[1:0], 6'h00}, 8'h07, 8'h0A, 8'h04, 8'hC5);
      settle();
      chk(scan_region_select, k[1:0], "scan field");
      chk(scan_enable, k != 3, "scan enable");
      chk(scan_limit_blk, lim[k], "scan limit");
      chk(boot_limit_blk, 9'd4, "boot limit");
      chk(app_limit_blk, 9'd10, "app limit");
    end
  endtask

  task automatic t_limits();
    rst_with(8'h40, 8'h07, 8'h00, 8'h00, 8'hC5);
    settle();
    chk(boot_limit_blk, 9'd16, "both zero boot");
    chk(scan_limit_blk, 9'd16, "boot scan top");
    rst_with(8'h80, 8'h07, 8'h00, 8'h03, 8'hC5);
    settle();
    chk(boot_limit_blk, 9'd3, "boot only");
    chk(app_limit_blk, 9'd16, "app to top");
    chk(scan_limit_blk, 9'd16, "boot plus app scan");
  endtask

  task automatic t_pin();
    int n;
    logic [31:0] d;
    for (int k = 0; k < 4; k++)
    begin
      rst_with({4'hC, k[1:0], 2'b00}, 8'h00, 8'h00, 8'h00, 8'hC5);
      n = 0;
      do
      begin
        @(posedge ref_clk);
        #1;
        n++;
        if (n == 2)
          chk({pin_func_reset, pin_func_prog, pin_func_gpio}, (k == 3) ? 3'b000 : 3'b001 << k, "pin");
      end while (gpio_drive_allow !== 1'b1 && n < 3300);
      if (k == 0)
        chk(n >= 768 * OD && n <= 769 * OD + 6, 1'b1, "gpio hold length");
      else
        chk(gpio_drive_allow, 1'b0, "no gpio drive");
      ahb_rd(32'h2C, d);
      chk(d[0], k == 0, "status gpio");
    end
  endtask

  task automatic t_startup();
    int n;
    int dl;
    for (int k = 0; k < 8; k++)
    begin
      rst_with(8'hCC, {5'h00, k[2:0]}, 8'h00, 8'h00, 8'hC5);
      dl = (k == 0) ? 0 : (1 << (k - 1)) * MD;
      n = 0;
      do
      begin
        @(posedge ref_clk);
        #1;
        n++;
      end while (startup_done !== 1'b1 && n < 1000);
      chk(n >= dl && n <= dl + 4, 1'b1, "startup delay");
    end
  endtask

  task automatic t_erase();
    for (int i = 0; i < 4; i++)
    begin
      rst_with({7'h62, i[0]}, 8'h00, 8'h00, 8'h00, i[1] ? 8'h00 : 8'hC5);
      settle();
      ahb_wr(32'h30, 32'h1);
      chk(chip_erase_stb, 1'b1, "erase pulse");
      chk(eeprom_erase, !i[0] || i[1], "eeprom erase");
      @(posedge ref_clk);
      #1;
      chk(chip_erase_stb, 1'b0, "erase pulse width");
    end
  endtask

  task automatic t_prog();
    logic [31:0] d;
    for (int i = 0; i < 2; i++)
    begin
      rst_with(8'h04, 8'h00, 8'h00, 8'h00, i ? 8'hC4 : 8'hC5);
      settle();
      @(posedge ref_clk);
      prog_bus_req <= 1'b1;
      prog_info_req <= 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      chk(prog_bus_grant, i == 0, "bus grant");
      chk(prog_info_grant, 1'b1, "info grant");
      prog_bus_req <= 1'b0;
      prog_info_req <= 1'b0;
      ahb_rd(32'h2C, d);
      chk(d[2], i == 1, "lock status");
    end
  endtask

  initial
  begin
    t_regs();
    t_scan();
    t_limits();
    t_pin();
    t_startup();
    t_erase();
    t_prog();
    conclude();
  end

endmodule

// File: sfcd_tick_div.sv
// divider that emits a one-cycle enable every DIV clocks
`timescale 1ns/1ps
module sfcd_tick_div #(
  parameter int unsigned DIV = 8
) (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  output logic      tick
);
  localparam int unsigned CW = $clog2(DIV + 1);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          tick_nxt;

  // ==========================================================================
  // count
  always_comb
  begin
    tick_nxt = (cnt_r == CW'(DIV - 1));
    cnt_nxt  = tick_nxt ? '0 : cnt_r + 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      tick  <= tick_nxt;
    end
  end
endmodule

// File: sfcd_top.sv
// system fuse configuration decoder with an AHB-Lite register slave
//
// Overview of operation
// - scan source picks checked flash region
// - pin field selects gpio, prog, reset
// - gpio driver off 768 slow-oscillator cycles
// - keep bit spares eeprom on erase
// - locked device always erases eeprom
// - startup field gives 0 to 64 ms
// - app end in 256-byte blocks
// - zero app end: code to top
// - zero boot end: whole flash boot
// - both zero: whole flash boot
// - only key 0xC5 unlocks memory
// - locked: prog interface denied bus
`timescale 1ns/1ps
module sfcd_top
  import sfcd_pkg::*;
#(
  parameter int unsigned OSC_DIV    = sfcd_pkg::SLOW_OSC_DIV,
  parameter int unsigned MSEC_DIV   = sfcd_pkg::MS_DIV,
  parameter int unsigned HOLD_TICKS = sfcd_pkg::GPIO_HOLD_TICKS,
  parameter int unsigned FLASH_BLK  = sfcd_pkg::FLASH_BLOCKS
) (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [7:0]  nv_cfg0,
  input  wire logic [7:0]  nv_cfg1,
  input  wire logic [7:0]  nv_app_end,
  input  wire logic [7:0]  nv_boot_end,
  input  wire logic [7:0]  nv_lock_key,
  input  wire logic        prog_bus_req,
  input  wire logic        prog_info_req,
  output logic             prog_bus_grant,
  output logic             prog_info_grant,
  output logic             scan_enable,
  output logic [1:0]       scan_region_select,
  output logic [8:0]       scan_limit_blk,
  output logic [8:0]       boot_limit_blk,
  output logic [8:0]       app_limit_blk,
  output logic             pin_func_gpio,
  output logic             pin_func_prog,
  output logic             pin_func_reset,
  output logic             gpio_drive_allow,
  output logic             startup_done,
  output logic             chip_erase_stb,
  output logic             eeprom_erase,
  output logic             lock_wr_stb,
  output logic [7:0]       lock_wr_data
);
  import sfcd_pkg::*;

  localparam logic [8:0] TOP_BLK = 9'(FLASH_BLK);

  // ==========================================================================
  // captured configuration bytes
  logic [7:0] cfg0_r;
  logic [7:0] cfg1_r;
  logic [7:0] app_end_r;
  logic [7:0] boot_end_r;
  logic [7:0] lock_r;
  logic [7:0] cfg0_nxt;
  logic [7:0] cfg1_nxt;
  logic [7:0] app_end_nxt;
  logic [7:0] boot_end_nxt;
  logic [7:0] lock_nxt;

  // stored bytes only matter while reset is held; later edits wait for the next reset
  always_comb
  begin
    cfg0_nxt     = cfg0_r;
    cfg1_nxt     = cfg1_r;
    app_end_nxt  = app_end_r;
    boot_end_nxt = boot_end_r;
    lock_nxt     = lock_r;
    if (sys_rst)
    begin
      cfg0_nxt     = nv_cfg0;
      cfg1_nxt     = nv_cfg1;
      app_end_nxt  = nv_app_end;
      boot_end_nxt = nv_boot_end;
      lock_nxt     = nv_lock_key;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    cfg0_r     <= cfg0_nxt;
    cfg1_r     <= cfg1_nxt;
    app_end_r  <= app_end_nxt;
    boot_end_r <= boot_end_nxt;
    lock_r     <= lock_nxt;
  end

  // ==========================================================================
  // field decode
  logic [1:0] scan_sel;
  logic [1:0] pin_sel;
  logic [2:0] dly_sel;
  logic       keep_ee;
  logic       locked;
  logic [8:0] boot_lim_c;
  logic [8:0] app_lim_c;
  logic [8:0] scan_lim_c;
  logic [6:0] dly_ms;

  always_comb
  begin
    scan_sel = cfg0_r[SCAN_LSB +: 2];
    pin_sel  = cfg0_r[PIN_LSB +: 2];
    keep_ee  = cfg0_r[KEEP_BIT];
    dly_sel  = cfg1_r[START_LSB +: 3];
    locked   = (lock_r != UNLOCK_KEY);
    // a zero boot end wins over any app end value
    if (boot_end_r == 8'h00)
    begin
      boot_lim_c = TOP_BLK;
      app_lim_c  = TOP_BLK;
    end
    else
    begin
      boot_lim_c = {1'b0, boot_end_r};
      app_lim_c  = (app_end_r == 8'h00) ? TOP_BLK : {1'b0, app_end_r};
    end
    unique case (scan_sel)
      SCAN_FULL:         scan_lim_c = TOP_BLK;
      SCAN_BOOT:         scan_lim_c = boot_lim_c;
      SCAN_BOOT_AND_APP: scan_lim_c = app_lim_c;
      SCAN_DISABLED:     scan_lim_c = 9'h000;
    endcase
    // codes 1..7 double from 1 ms
    dly_ms = (dly_sel == 3'h0) ? 7'h00 : 7'(7'h01 << (dly_sel - 3'h1));
  end

  // ==========================================================================
  // post-reset timers
  logic        osc_tick;
  logic        ms_tick;
  logic        hold_done;
  logic        run_done;
  logic [9:0]  hold_target;

  assign hold_target = (pin_sel == PIN_GPIO) ? 10'(HOLD_TICKS) : 10'h000;

  sfcd_tick_div #(.DIV(OSC_DIV)) u_osc_div (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .tick    (osc_tick)
  );

  sfcd_tick_div #(.DIV(MSEC_DIV)) u_ms_div (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .tick    (ms_tick)
  );

  sfcd_hold_cnt #(.W(10)) u_gpio_hold (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .tick    (osc_tick),
    .target  (hold_target),
    .done    (hold_done)
  );

  sfcd_hold_cnt #(.W(7)) u_startup (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .tick    (ms_tick),
    .target  (dly_ms),
    .done    (run_done)
  );

  // ==========================================================================
  // AHB-Lite slave, zero wait states, always OKAY
  logic        dph_r;
  logic        dph_wr_r;
  logic [7:0]  dph_idx_r;
  logic        dph_nxt;
  logic        dph_wr_nxt;
  logic [7:0]  dph_idx_nxt;
  logic [31:0] rdata_nxt;
  logic        take;
  logic [7:0]  a_idx;
  logic [7:0]  rd_byte;
  logic        wr_lock;
  logic        wr_erase;

  always_comb
  begin
    take        = hsel && htrans[1] && hready;
    a_idx       = (haddr[31:10] == 22'h0 && haddr[1:0] == 2'b00) ? haddr[9:2] : 8'hFF;
    wr_lock     = dph_r && dph_wr_r && (dph_idx_r == IDX_LOCK);
    wr_erase    = dph_r && dph_wr_r && (dph_idx_r == IDX_ERASE) && hwdata[ERASE_BIT];
    dph_nxt     = take;
    dph_wr_nxt  = take && hwrite;
    dph_idx_nxt = take ? a_idx : dph_idx_r;
    unique case (a_idx)
      IDX_CFG0:     rd_byte = cfg0_r;
      IDX_CFG1:     rd_byte = cfg1_r;
      IDX_APP_END:  rd_byte = app_end_r;
      IDX_BOOT_END: rd_byte = boot_end_r;
      IDX_LOCK:     rd_byte = lock_r;
      IDX_STATUS:   rd_byte = 8'(({5'h00, locked, startup_done, gpio_drive_allow}));
      default:      rd_byte = 8'h00;
    endcase
    rdata_nxt = hrdata;
    if (take && !hwrite)
      rdata_nxt = {24'h000000, rd_byte};
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      dph_r     <= 1'b0;
      dph_wr_r  <= 1'b0;
      dph_idx_r <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      dph_r     <= dph_nxt;
      dph_wr_r  <= dph_wr_nxt;
      dph_idx_r <= dph_idx_nxt;
      hrdata    <= rdata_nxt;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ==========================================================================
  // decoded outputs
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      scan_enable        <= 1'b0;
      scan_region_select <= SCAN_DISABLED;
      scan_limit_blk     <= 9'h000;
      boot_limit_blk     <= 9'h000;
      app_limit_blk      <= 9'h000;
      pin_func_gpio      <= 1'b0;
      pin_func_prog      <= 1'b0;
      pin_func_reset     <= 1'b0;
      gpio_drive_allow   <= 1'b0;
      startup_done       <= 1'b0;
      prog_bus_grant     <= 1'b0;
      prog_info_grant    <= 1'b0;
      chip_erase_stb     <= 1'b0;
      eeprom_erase       <= 1'b0;
      lock_wr_stb        <= 1'b0;
      lock_wr_data       <= 8'h00;
    end
    else
    begin
      scan_enable        <= (scan_sel != SCAN_DISABLED);
      scan_region_select <= scan_sel;
      scan_limit_blk     <= scan_lim_c;
      boot_limit_blk     <= boot_lim_c;
      app_limit_blk      <= app_lim_c;
      pin_func_gpio      <= (pin_sel == PIN_GPIO);
      pin_func_prog      <= (pin_sel == PIN_PROG);
      pin_func_reset     <= (pin_sel == PIN_RESET);
      // driver stays off so a high-voltage enable sequence cannot fight it
      gpio_drive_allow   <= (pin_sel == PIN_GPIO) && hold_done;
      startup_done       <= run_done;
      prog_bus_grant     <= prog_bus_req && !locked;
      prog_info_grant    <= prog_info_req;
      chip_erase_stb     <= wr_erase;
      eeprom_erase       <= wr_erase && (!keep_ee || locked);
      lock_wr_stb        <= wr_lock;
      lock_wr_data       <= wr_lock ? hwdata[7:0] : lock_wr_data;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  scan_region_a: assert property (!$past(sys_rst) |-> scan_enable == (scan_sel != SCAN_DISABLED) &&
    (scan_sel != SCAN_BOOT || scan_limit_blk == boot_limit_blk)) else $error("scan region wrong");
  pin_func_a: assert property (!$past(sys_rst) |-> pin_func_reset == (pin_sel == PIN_RESET) &&
    pin_func_prog == (pin_sel == PIN_PROG)) else $error("pin function wrong");
  gpio_hold_a: assert property ($fell(sys_rst) |-> !gpio_drive_allow [*8]) else $error("driver early");
  eeprom_keep_a: assert property (chip_erase_stb |-> eeprom_erase == (!keep_ee || locked))
    else $error("eeprom keep wrong");
  locked_erase_a: assert property (wr_erase && locked |=> eeprom_erase) else $error("locked erase kept eeprom");
  startup_zero_a: assert property ($fell(sys_rst) && dly_sel == 3'h0 |-> ##[1:3] startup_done)
    else $error("zero startup late");
  app_end_a: assert property (!$past(sys_rst) && boot_end_r != 8'h00 && app_end_r != 8'h00 |->
    app_limit_blk == {1'b0, app_end_r}) else $error("app end wrong");
  app_zero_a: assert property (!$past(sys_rst) && boot_end_r != 8'h00 && app_end_r == 8'h00 |->
    app_limit_blk == TOP_BLK) else $error("app zero wrong");
  boot_zero_a: assert property (!$past(sys_rst) && boot_end_r == 8'h00 |->
    boot_limit_blk == TOP_BLK && app_limit_blk == TOP_BLK) else $error("boot zero wrong");
  lock_key_a: assert property (prog_bus_req && lock_r == UNLOCK_KEY |=> prog_bus_grant)
    else $error("key not unlocking");
  bus_deny_a: assert property (locked |=> !prog_bus_grant) else $error("locked bus granted");
  hold_cfg_a: assert property (!$past(sys_rst) |-> $stable(cfg0_r) && $stable(lock_r))
    else $error("config changed");

  gpio_on_c: cover property ($rose(gpio_drive_allow));
  locked_erase_c: cover property (chip_erase_stb && eeprom_erase && locked);
  read_cfg_c: cover property (take && !hwrite && a_idx == IDX_CFG0);
  startup_c: cover property ($rose(startup_done));
endmodule
